// *** rtl/fls_top.v ***
// fan step table entries five and six: registers, compare and duty select
//
// How it works
// - low-res temperature mode: limit top bit reads 0
// - high-res: 8-bit limit compared, 0 to 127.5
// - low-res: 7-bit limit compared, range 0 to 127
// - remote above limit selects paired duty value
// - limits are unsigned, sign taken as zero
// - high-res duty uses extended bits; else read 0
// - extended duty bits need 22.5 kHz PWM
// - low-res duty uses the six lower bits
// - table offset raises effective limits above 127
`timescale 1ns/1ps
`include "fls_defs.vh"

module fls_top
(
    // clock and reset
    input  wire        clk_in,
    input  wire        srst_in,
    // register port
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_rvalid_out,
    output reg         wr_refused_out,
    // mode and control settings from the rest of the device
    input  wire [7:0]  table_ctrl_in,
    input  wire        temp_hires_in,
    input  wire        duty_hires_in,
    input  wire        pwm_freq_22k5_in,
    input  wire [7:0]  table_offset_in,
    // remote temperature reading, unsigned, 1/8 degree lsb
    input  wire [10:0] remote_temp_in,
    // fan drive request
    output reg  [7:0]  duty_out,
    output reg         duty_valid_out,
    output reg  [1:0]  active_step_out,
    output reg         step5_exceed_out,
    output reg         step6_exceed_out,
    output reg         duty_ext_active_out
);

    // =================================================================
    // register storage
    // even index holds a temperature limit, odd index the paired duty
    reg  [7:0] fan_step_table [0:3];

    wire [7:0] table_offs;
    wire       table_hit;
    wire [1:0] table_idx;
    wire       idx_is_duty;
    wire       wr_enabled;
    wire       duty_ext_ok;

    assign table_offs  = reg_addr_in - `FLS_TABLE_BASE;
    assign table_hit   = (table_offs < `FLS_TABLE_DEPTH);
    assign table_idx   = table_offs[1:0];
    assign idx_is_duty = table_idx[0];
    assign wr_enabled  = table_ctrl_in[`FLS_WREN_BIT];
    assign duty_ext_ok = duty_hires_in & pwm_freq_22k5_in;

    // =================================================================
    // write decode
    // one load strobe per slot keeps each entry flop a single driver
    // a locked write loads nothing but is still reported
    wire       wr_hit;
    wire [3:0] entry_wr;

    assign wr_hit   = reg_wr_in & table_hit;
    assign entry_wr = (wr_hit & wr_enabled) ? (4'h1 << table_idx) : 4'h0;

    // =================================================================
    // write masking
    // unused bits are stored as zero so they stay zero after a mode change
    reg [7:0] next_entry;

    always @*
    begin
        next_entry = reg_wdata_in;
        if (idx_is_duty)
        begin
            if (!duty_hires_in)
            begin
                next_entry = {2'h0, reg_wdata_in[`FLS_DUTY_BASE_MSB:0]};
            end
        end
        else
        begin
            if (!temp_hires_in)
            begin
                next_entry = {1'h0, reg_wdata_in[`FLS_INT_MSB:0]};
            end
        end
    end

    // =================================================================
    // table write, one flop per entry
    genvar e;
    generate
        for (e = 0; e < 4; e = e + 1)
        begin : g_entry
            always @(posedge clk_in)
            begin
                if (srst_in)
                begin
                    if (e % 2 == 0)
                    begin
                        fan_step_table[e] <= `FLS_LIMIT_RST;
                    end
                    else
                    begin
                        fan_step_table[e] <= `FLS_DUTY_RST;
                    end
                end
                else if (entry_wr[e])
                begin
                    fan_step_table[e] <= next_entry;
                end
            end
        end
    endgenerate

    // write attempt while locked is flagged for one cycle, data kept
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_refused_out <= 1'b0;
        end
        else
        begin
            wr_refused_out <= wr_hit & ~wr_enabled;
        end
    end

    // =================================================================
    // register read
    // masking on read too, since stored bits may predate a mode switch
    reg [7:0] next_rdata;
    reg [7:0] raw_entry;

    always @*
    begin
        raw_entry  = fan_step_table[table_idx];
        next_rdata = `FLS_READ_IDLE;
        if (table_hit)
        begin
            if (idx_is_duty)
            begin
                if (duty_hires_in)
                begin
                    next_rdata = raw_entry;
                end
                else
                begin
                    next_rdata = {2'h0, raw_entry[`FLS_DUTY_BASE_MSB:0]};
                end
            end
            else
            begin
                if (temp_hires_in)
                begin
                    next_rdata = raw_entry;
                end
                else
                begin
                    next_rdata = {1'h0, raw_entry[`FLS_INT_MSB:0]};
                end
            end
        end
    end

    // rdata holds the last read so a slow host may pick it up late
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            reg_rdata_out  <= `FLS_READ_IDLE;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // =================================================================
    // per step compare
    wire [`FLS_STEPS-1:0] step_exceed;
    wire [7:0]            step_duty [0:`FLS_STEPS-1];

    genvar s;
    generate
        for (s = 0; s < `FLS_STEPS; s = s + 1)
        begin : g_step
            fls_step u_step
            (
                .limit_in       (fan_step_table[2*s]),
                .duty_in        (fan_step_table[2*s+1]),
                .temp_hires_in  (temp_hires_in),
                .duty_ext_ok_in (duty_ext_ok),
                .offset_in      (table_offset_in),
                .remote_in      (remote_temp_in),
                .exceed_out     (step_exceed[s]),
                .duty_out       (step_duty[s])
            );
        end
    endgenerate

    // =================================================================
    // step selection state
    // one-hot selection; the higher step wins when both limits are passed
    localparam [2:0] SEL_NONE = 3'h1;
    localparam [2:0] SEL_FIVE = 3'h2;
    localparam [2:0] SEL_SIX  = 3'h4;

    reg [2:0] next_sel;
    reg [7:0] next_duty;
    reg [1:0] next_step;

    always @*
    begin
        if (step_exceed[1])
        begin
            next_sel = SEL_SIX;
        end
        else if (step_exceed[0])
        begin
            next_sel = SEL_FIVE;
        end
        else
        begin
            next_sel = SEL_NONE;
        end
    end

    always @*
    begin
        case (next_sel)
            SEL_SIX:
            begin
                next_duty = step_duty[1];
                next_step = `FLS_SEL_SIX;
            end
            SEL_FIVE:
            begin
                next_duty = step_duty[0];
                next_step = `FLS_SEL_FIVE;
            end
            default:
            begin
                next_duty = `FLS_READ_IDLE;
                next_step = `FLS_SEL_NONE;
            end
        endcase
    end

    // =================================================================
    // registered fan drive request
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            duty_out            <= `FLS_READ_IDLE;
            duty_valid_out      <= 1'b0;
            active_step_out     <= `FLS_SEL_NONE;
            duty_ext_active_out <= 1'b0;
        end
        else
        begin
            duty_out            <= next_duty;
            duty_valid_out      <= (next_sel != SEL_NONE);
            active_step_out     <= next_step;
            duty_ext_active_out <= duty_ext_ok;
        end
    end

    // raw compare results, kept apart from the drive request so each
    // step can be watched even while the other one wins the selection
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            step5_exceed_out <= 1'b0;
            step6_exceed_out <= 1'b0;
        end
        else
        begin
            step5_exceed_out <= step_exceed[0];
            step6_exceed_out <= step_exceed[1];
        end
    end

endmodule // fls_top

// *** rtl/fls_defs.vh ***
// constants shared by the fan step table entries five and six
`ifndef FLS_DEFS_VH
`define FLS_DEFS_VH

// =====================================================================
// register map
`define FLS_ADDR_LIMIT_FIVE   8'h58
`define FLS_ADDR_DUTY_FIVE    8'h59
`define FLS_ADDR_LIMIT_SIX    8'h5A
`define FLS_ADDR_DUTY_SIX     8'h5B
`define FLS_TABLE_BASE        8'h58
`define FLS_TABLE_DEPTH       8'h04
`define FLS_STEPS             2

// =====================================================================
// reset values
`define FLS_LIMIT_RST         8'h7F
`define FLS_DUTY_RST          8'h3F
`define FLS_READ_IDLE         8'h00

// =====================================================================
// field positions
`define FLS_WREN_BIT          5
`define FLS_HALF_BIT          7
`define FLS_INT_MSB           6
`define FLS_DUTY_BASE_MSB     5
`define FLS_DUTY_EXT_LSB      6
`define FLS_DUTY_EXT_MSB      7
`define FLS_REM_MSB           10
`define FLS_REM_HALF_LSB      2
`define FLS_REM_DEG_LSB       3

// =====================================================================
// active step codes
`define FLS_SEL_NONE          2'h0
`define FLS_SEL_FIVE          2'h1
`define FLS_SEL_SIX           2'h2

`endif

// *** rtl/fls_step.v ***
// one fan table step: limit compare and duty value selection
`timescale 1ns/1ps
`include "fls_defs.vh"

module fls_step
(
    // table entry contents
    input  wire [7:0]  limit_in,
    input  wire [7:0]  duty_in,
    // modes
    input  wire        temp_hires_in,
    input  wire        duty_ext_ok_in,
    input  wire [7:0]  offset_in,
    // remote reading, unsigned, 1/8 degree lsb
    input  wire [10:0] remote_in,
    // results
    output wire        exceed_out,
    output wire [7:0]  duty_out
);

    // =================================================================
    // limit forming
    wire [8:0] remote_half;
    wire [7:0] remote_deg;
    wire [9:0] eff_half;
    wire [8:0] eff_deg;
    wire       exceed_hi;
    wire       exceed_lo;

    // sign taken as zero, so limits never go negative
    assign remote_half = remote_in[`FLS_REM_MSB:`FLS_REM_HALF_LSB];
    assign remote_deg  = remote_in[`FLS_REM_MSB:`FLS_REM_DEG_LSB];

    // half degree bit is the lsb of an 8 bit limit, offset lifts range
    assign eff_half = {2'h0, limit_in[`FLS_INT_MSB:0], limit_in[`FLS_HALF_BIT]}
                    + {1'h0, offset_in, 1'h0};
    // integer degrees only, top bit ignored
    assign eff_deg  = {2'h0, limit_in[`FLS_INT_MSB:0]} + {1'h0, offset_in};

    assign exceed_hi = ({1'h0, remote_half} > eff_half);
    assign exceed_lo = ({1'h0, remote_deg} > eff_deg);
    assign exceed_out = temp_hires_in ? exceed_hi : exceed_lo;

    // =================================================================
    // duty value
    // extended bits count only in high res duty at 22.5 kHz
    assign duty_out = duty_ext_ok_in ? duty_in
                                     : {2'h0, duty_in[`FLS_DUTY_BASE_MSB:0]};

endmodule // fls_step

// *** testbench/fls_props.sv ***
// concurrent checks on the fan step table ports
`timescale 1ns/1ps
module fls_props
(
    // clock and reset
    input wire        clk_in,
    input wire        srst_in,
    // register port
    input wire [7:0]  reg_addr_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_rdata_out,
    input wire        wr_refused_out,
    // modes and reading
    input wire [7:0]  table_ctrl_in,
    input wire        temp_hires_in,
    input wire        duty_hires_in,
    input wire        pwm_freq_22k5_in,
    input wire [10:0] remote_temp_in,
    // fan drive
    input wire [7:0]  duty_out,
    input wire        duty_valid_out,
    input wire [1:0]  active_step_out,
    input wire        step5_exceed_out,
    input wire        step6_exceed_out,
    input wire        duty_ext_active_out
);
    // ==========================================================
    // sequences
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire mapped = reg_addr_in[7:2] == 6'h16;
    sequence lock_wr_s;
        reg_wr_in && mapped && !table_ctrl_in[5];
    endsequence
    sequence lim_rd_s;
        reg_rd_in && mapped && !reg_addr_in[0];
    endsequence
    // ==========================================================
    // assertions
    lock_refuse_a: assert property (lock_wr_s |=> wr_refused_out)
        else $error("locked write not refused");
    open_write_a: assert property (reg_wr_in && table_ctrl_in[5] |=> !wr_refused_out)
        else $error("open write refused");
    limit_mask_a: assert property (lim_rd_s ##0 !temp_hires_in |=> !reg_rdata_out[7])
        else $error("limit top bit set in low res");
    duty_mask_a: assert property (reg_rd_in && mapped && reg_addr_in[0] && !duty_hires_in
        |=> reg_rdata_out[7:6] == 2'h0)
        else $error("duty ext bits set in low res");
    ext_gate_a: assert property (1'b1 |=> duty_ext_active_out == $past(duty_hires_in
        && pwm_freq_22k5_in))
        else $error("ext duty gate wrong");
    base_duty_a: assert property (!duty_ext_active_out |-> duty_out[7:6] == 2'h0)
        else $error("ext duty bits used while gated");
    six_wins_a: assert property (step6_exceed_out |-> active_step_out == 2'h2 && duty_valid_out)
        else $error("step six not selected");
    five_sel_a: assert property (step5_exceed_out && !step6_exceed_out
        |-> active_step_out == 2'h1 && duty_valid_out)
        else $error("step five not selected");
    idle_duty_a: assert property (!step5_exceed_out && !step6_exceed_out
        |-> duty_out == 8'h00 && !duty_valid_out && active_step_out == 2'h0)
        else $error("duty driven with no step");
    cold_reading_a: assert property (remote_temp_in[10:2] == 9'h000
        |=> !step5_exceed_out && !step6_exceed_out)
        else $error("zero reading exceeded a limit");
endmodule // fls_props

bind fls_top fls_props props_u (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .wr_refused_out(wr_refused_out), .table_ctrl_in(table_ctrl_in),
    .temp_hires_in(temp_hires_in), .duty_hires_in(duty_hires_in),
    .pwm_freq_22k5_in(pwm_freq_22k5_in), .remote_temp_in(remote_temp_in),
    .duty_out(duty_out), .duty_valid_out(duty_valid_out), .active_step_out(active_step_out),
    .step5_exceed_out(step5_exceed_out), .step6_exceed_out(step6_exceed_out),
    .duty_ext_active_out(duty_ext_active_out));

// *** testbench/fls_host.sv ***
// host model issuing table register accesses
`timescale 1ns/1ps
module fls_host
(
    // clock
    input  wire       clk_in,
    // register port towards the table
    output reg  [7:0] reg_addr_out,
    output reg        reg_wr_out,
    output reg  [7:0] reg_wdata_out,
    output reg        reg_rd_out,
    input  wire [7:0] reg_rdata_in,
    input  wire       reg_rvalid_in,
    input  wire       wr_refused_in
);
    initial
    begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    // ==========================================================
    // accesses; released fields inverted so stale values never match
    task wr_reg(input [7:0] a, input [7:0] d, output rf);
    begin
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
        #1 rf = wr_refused_in;
    end
    endtask
    task rd_reg(input [7:0] a, output [7:0] d, output ok);
    begin
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1 ok = reg_rvalid_in;
        d = reg_rdata_in;
    end
    endtask
endmodule // fls_host

// *** testbench/fan_lut_entries_five_six_tb_top.sv ***
// self-checking bench for fan step table entries five and six
`timescale 1ns/1ps
module fan_lut_entries_five_six_tb_top;
    reg         clk_in, srst_in, thi, dhi, f22, ok, rf;
    reg  [7:0]  ctrl, off, a, d, got, lm;
    reg  [10:0] remote;
    reg  [9:0]  b;
    reg  [31:0] seed;
    reg  [7:0]  mem [0:3];
    integer     failures, n_compared, i;
    wire [7:0]  addr, wdata, rdata, duty;
    wire        wr, rd, rvalid, refused, dvalid, s5, s6, ext;
    wire [1:0]  step;
    fls_host host_u (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata),
        .reg_rvalid_in(rvalid), .wr_refused_in(refused));
    fls_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .wr_refused_out(refused), .table_ctrl_in(ctrl), .temp_hires_in(thi),
        .duty_hires_in(dhi), .pwm_freq_22k5_in(f22), .table_offset_in(off),
        .remote_temp_in(remote), .duty_out(duty), .duty_valid_out(dvalid),
        .active_step_out(step), .step5_exceed_out(s5), .step6_exceed_out(s6),
        .duty_ext_active_out(ext));
    // ==========================================================
    // expectations
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] view(input [1:0] k, input [7:0] v);
        view = k[0] ? (dhi ? v : v & 8'h3F) : (thi ? v : v & 8'h7F);
    endfunction
    // {step six exceeded, step five exceeded}
    function [1:0] exp_hit(input [10:0] r);
        reg [9:0] l5, l6;
        begin
            l5 = thi ? {mem[0][6:0], mem[0][7]} + 2 * off : mem[0][6:0] + off;
            l6 = thi ? {mem[2][6:0], mem[2][7]} + 2 * off : mem[2][6:0] + off;
            exp_hit = {(thi ? r[10:2] : r[10:3]) > l6, (thi ? r[10:2] : r[10:3]) > l5};
        end
    endfunction
    function [10:0] exp_fan(input [10:0] r);
        reg [1:0] h;
        reg [7:0] dv;
        begin
            h = exp_hit(r);
            dv = h[1] ? mem[3] : (h[0] ? mem[1] : 8'h00);
            if (!(dhi && f22))
                dv = dv & 8'h3F;
            exp_fan = {h[0] | h[1], h[1] ? 2'h2 : {1'b0, h[0]}, dv};
        end
    endfunction
    task chk(input [10:0] g, input [10:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    // outputs follow one edge after the reading lands
    task fan_chk(input [10:0] r);
    begin
        @(posedge clk_in);
        remote <= r;
        @(posedge clk_in);
        #1 chk({dvalid, step, duty}, exp_fan(r));
        chk({8'h00, s6, s5, ext}, {8'h00, exp_hit(r), dhi && f22});
    end
    endtask
    task finish_test;
    begin
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // ==========================================================
    // clock, watchdog, sequence
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        failures = failures + 1;
        finish_test;
    end
    initial
    begin
        srst_in = 1'b1; ctrl = 8'h00; thi = 1'b1; dhi = 1'b1; f22 = 1'b1;
        off = 8'h00; remote = 11'h000; failures = 0; n_compared = 0; seed = 94825;
        mem[0] = 8'h7F; mem[1] = 8'h3F; mem[2] = 8'h7F; mem[3] = 8'h3F;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        fan_chk(11'h000);
        for (i = 0; i < 6; i = i + 1)
        begin
            a = 8'h57 + i;
            host_u.rd_reg(a, got, ok);
            chk({ok, 2'h0, got}, {3'h4, a[7:2] == 6'h16 ? mem[a[1:0]] : 8'h00});
        end
        for (i = 0; i < 80; i = i + 1)
        begin
            seed = lfsr(seed);
            @(posedge clk_in);
            ctrl <= seed[7:0]; thi <= seed[8]; dhi <= seed[9];
            f22 <= seed[10] | seed[11]; off <= {4'h0, seed[15:12]};
            a = 8'h56 + seed[18:16];
            d = seed[27:20];
            @(posedge clk_in);
            host_u.wr_reg(a, d, rf);
            chk({10'h0, rf}, {10'h0, a[7:2] == 6'h16 && !ctrl[5]});
            if (a[7:2] == 6'h16 && ctrl[5])
                mem[a[1:0]] = view(a[1:0], d);
            host_u.rd_reg(a, got, ok);
            chk({ok, 2'h0, got}, {3'h4, a[7:2] == 6'h16 ? view(a[1:0], mem[a[1:0]]) : 8'h00});
            fan_chk(seed[31:21]);
            // reading exactly at a limit, or one step above it
            lm = mem[{seed[30], 1'b0}];
            b = (thi ? {lm[6:0], lm[7]} + 2 * off : lm[6:0] + off) + seed[29];
            fan_chk(thi ? {b[8:0], 2'b00} : {b[7:0], 3'b000});
        end
        finish_test;
    end
endmodule // fan_lut_entries_five_six_tb_top
